// ---- motor_speed_params.svh ----
// constants of the speed control core: offsets, reset values, timing
`ifndef MOTOR_SPEED_PARAMS_SVH
`define MOTOR_SPEED_PARAMS_SVH
`define MSP_CTRL          8'h00
`define MSP_DROOP_PCT     8'h04
`define MSP_DROOP_TIME    8'h08
`define MSP_OL_P          8'h0C
`define MSP_OL_I          8'h10
`define MSP_CL_KP         8'h14
`define MSP_CL_TI         8'h18
`define MSP_START_HOLD    8'h1C
`define MSP_STOP_HOLD     8'h20
`define MSP_F0            8'h24
`define MSP_F1            8'h28
`define MSP_KP_F0         8'h2C
`define MSP_KP_FW         8'h30
`define MSP_ZERO_LIM      8'h34
`define MSP_FNOM          8'h38
`define MSP_FW_POINT      8'h3C
`define MSP_STATUS        8'h40
`define MSP_TORQUE        8'h44
`define MSP_FREQ          8'h48
`define MSP_CFG_WORDS     16
`define MSP_CTRL_CLOSED   0
`define MSP_CTRL_COAST    1
`define MSP_CTRL_SEL_LO   2
`define MSP_RST_CL_KP     16'h0064
`define MSP_RST_CL_TI     16'h0032
`define MSP_RST_PCT       16'h0064
`define MSP_RST_FNOM      16'h1388
`define MSP_GAIN_UNITY    32'sh00000064
`define MSP_TORQ_NOM      32'sh000003E8
`define MSP_TORQ_LIM      32'sh00007530
`define MSP_DROOP_DIV     32'sh000F4240
`define MSP_CLK_KHZ       20000
`define MSP_SAMPLE_US     1000
`endif

// ---- motor_speed_pkg.sv ----
// types of the speed control core
`include "motor_speed_params.svh"
package motor_speed_pkg;
    typedef enum logic [2:0] {
        ST_IDLE       = 3'b000,
        ST_START_HOLD = 3'b001,
        ST_RUN        = 3'b010,
        ST_DECEL      = 3'b011,
        ST_STOP_HOLD  = 3'b100
    } hold_state_t;

    typedef struct packed {
        logic [`MSP_CFG_WORDS-1:0][15:0] cfg;
        hold_state_t                     state;
        logic [15:0]                     hold_cnt;
        logic [14:0]                     div_cnt;
        logic                            tick;
        logic signed [31:0]              acc;
        logic signed [31:0]              err_prev;
        logic signed [31:0]              torq_flt;
        logic signed [15:0]              torque_ref;
        logic signed [15:0]              freq_target;
        logic                            ramp_release;
        logic                            zero_hold;
        logic [31:0]                     rd_data;
    } core_state_t;
endpackage : motor_speed_pkg

// ---- motor_speed_pi_droop_control.sv ----
// speed pi controller with load droop, zero speed holds and closed loop gain scheduling
`timescale 1ns/100ps
`include "motor_speed_params.svh"
module motor_speed_pi_droop_control #(
    parameter int SAMPLE_CYCLES = `MSP_CLK_KHZ * `MSP_SAMPLE_US / 1000
) (
    input  wire logic               ref_clk_in,
    input  wire logic               rst_b_in,
    input  wire logic [7:0]         addr_in,
    input  wire logic [31:0]        wr_data_in,
    input  wire logic               wr_in,
    input  wire logic               rd_in,
    output logic      [31:0]        rd_data_out,
    input  wire logic signed [15:0] ramp_freq_in,
    input  wire logic signed [15:0] actual_freq_in,
    input  wire logic signed [15:0] load_torque_in,
    input  wire logic               start_cmd_in,
    input  wire logic               stop_cmd_in,
    input  wire logic               ramp_at_zero_in,
    output logic signed [15:0]      torque_ref_out,
    output logic signed [15:0]      freq_target_out,
    output logic                    ramp_release_out,
    output logic                    zero_hold_out
);
    motor_speed_pkg::core_state_t s;
    motor_speed_pkg::core_state_t next_s;

    function automatic logic [15:0] abs16(input logic signed [15:0] v);
        abs16 = v[15] ? 16'(-v) : 16'(v);
    endfunction : abs16

    function automatic logic signed [31:0] wide(input logic [15:0] v);
        wide = $signed({16'h0000, v});
    endfunction : wide

    logic                     closed_loop;
    logic                     coast_stop;
    logic [1:0]               droop_sel;
    logic [15:0]              spd;
    logic signed [31:0]       gain_pct;
    logic signed [31:0]       kp_eff;
    logic signed [31:0]       torq_dev;
    logic signed [31:0]       drop;
    logic signed [31:0]       err;
    logic signed [31:0]       delta;
    logic signed [31:0]       acc_sum;
    logic                     active;
    logic                     hold_done;
    logic [15:0]              ti_safe;
    logic [15:0]              rt_safe;

    assign closed_loop = s.cfg[0][`MSP_CTRL_CLOSED];
    assign coast_stop  = s.cfg[0][`MSP_CTRL_COAST];
    assign droop_sel   = s.cfg[0][`MSP_CTRL_SEL_LO +: 2];
    // open loop has no encoder, so the ramp frequency stands in for speed
    assign spd         = closed_loop ? abs16(actual_freq_in) : abs16(ramp_freq_in);
    assign ti_safe     = (s.cfg[6] == 16'h0000) ? 16'h0001 : s.cfg[6];
    assign rt_safe     = (s.cfg[2] == 16'h0000) ? 16'h0001 : s.cfg[2];

    always_comb begin
        next_s = s;
        gain_pct = `MSP_GAIN_UNITY;
        kp_eff = 32'sh00000000;
        torq_dev = 32'sh00000000;
        drop = 32'sh00000000;
        err = 32'sh00000000;
        delta = 32'sh00000000;
        acc_sum = 32'sh00000000;
        active = 1'b0;
        hold_done = 1'b0;

        // register port
        if (wr_in && (addr_in[1:0] == 2'b00) && (addr_in < `MSP_STATUS)) begin
            next_s.cfg[addr_in[5:2]] = wr_data_in[15:0];
        end
        if (rd_in) begin
            next_s.rd_data = 32'h00000000;
            if ((addr_in[1:0] == 2'b00) && (addr_in < `MSP_STATUS)) begin
                next_s.rd_data = {16'h0000, s.cfg[addr_in[5:2]]};
            end else if (addr_in == `MSP_STATUS) begin
                next_s.rd_data = {27'h0000000, s.zero_hold, s.ramp_release, s.state};
            end else if (addr_in == `MSP_TORQUE) begin
                next_s.rd_data = {{16{s.torque_ref[15]}}, s.torque_ref};
            end else if (addr_in == `MSP_FREQ) begin
                next_s.rd_data = {{16{s.freq_target[15]}}, s.freq_target};
            end
        end

        // fixed sample period divider
        next_s.tick = 1'b0;
        if (32'(s.div_cnt) >= 32'(SAMPLE_CYCLES - 1)) begin
            next_s.div_cnt = 15'h0000;
            next_s.tick = 1'b1;
        end else begin
            next_s.div_cnt = 15'(s.div_cnt + 15'h0001);
        end

        // speed area gain, percent of base gain
        if (spd >= s.cfg[15]) begin
            gain_pct = wide(s.cfg[12]);
        end else if (spd >= s.cfg[10]) begin
            gain_pct = `MSP_GAIN_UNITY;
        end else if (spd <= s.cfg[9]) begin
            gain_pct = wide(s.cfg[11]);
        end else begin
            gain_pct = wide(s.cfg[11]) + ((`MSP_GAIN_UNITY - wide(s.cfg[11]))
                       * (wide(spd) - wide(s.cfg[9]))) / (wide(s.cfg[10]) - wide(s.cfg[9]));
        end
        kp_eff = (wide(s.cfg[5]) * gain_pct) / `MSP_GAIN_UNITY;

        // load droop; torque in 0.1 % of nominal, droop setting in 0.1 %
        if (s.cfg[2] == 16'h0000) begin
            torq_dev = 32'(load_torque_in);
        end else begin
            torq_dev = 32'(load_torque_in) - s.torq_flt;
        end
        drop = (wide(s.cfg[14]) * wide(s.cfg[1]) * torq_dev) / `MSP_DROOP_DIV;
        case (droop_sel)
            2'b01: begin
                if (spd < s.cfg[13]) begin
                    drop = (drop * wide(spd)) / wide(s.cfg[13]);
                end
            end
            2'b10: begin
                if (spd < s.cfg[14]) begin
                    drop = (drop * wide(spd)) / wide(s.cfg[14]);
                end
            end
            default: begin
                drop = drop;
            end
        endcase

        // zero speed hold sequencing, timers count sample periods (1 ms)
        hold_done = 1'b0;
        case (s.state)
            motor_speed_pkg::ST_IDLE: begin
                next_s.hold_cnt = 16'h0000;
                if (start_cmd_in) begin
                    next_s.state = motor_speed_pkg::ST_START_HOLD;
                end
            end
            motor_speed_pkg::ST_START_HOLD: begin
                active = 1'b1;
                // count one extra tick, as the first may come right after the command
                hold_done = (s.hold_cnt > s.cfg[7]);
                if (stop_cmd_in) begin
                    next_s.state = coast_stop ? motor_speed_pkg::ST_IDLE
                                              : motor_speed_pkg::ST_DECEL;
                end else if (hold_done) begin
                    next_s.state = motor_speed_pkg::ST_RUN;
                end else if (s.tick) begin
                    next_s.hold_cnt = 16'(s.hold_cnt + 16'h0001);
                end
            end
            motor_speed_pkg::ST_RUN: begin
                active = 1'b1;
                if (stop_cmd_in) begin
                    next_s.state = coast_stop ? motor_speed_pkg::ST_IDLE
                                              : motor_speed_pkg::ST_DECEL;
                end
            end
            motor_speed_pkg::ST_DECEL: begin
                active = 1'b1;
                next_s.hold_cnt = 16'h0000;
                // the ramp's own zero, not measured speed, which may lag it
                if (ramp_at_zero_in) begin
                    next_s.state = motor_speed_pkg::ST_STOP_HOLD;
                end
            end
            motor_speed_pkg::ST_STOP_HOLD: begin
                active = 1'b1;
                if (s.hold_cnt > s.cfg[8]) begin
                    next_s.state = motor_speed_pkg::ST_IDLE;
                end else if (s.tick) begin
                    next_s.hold_cnt = 16'(s.hold_cnt + 16'h0001);
                end
            end
            default: begin
                next_s.state = motor_speed_pkg::ST_IDLE;
            end
        endcase
        next_s.ramp_release = (next_s.state == motor_speed_pkg::ST_RUN)
                           || (next_s.state == motor_speed_pkg::ST_DECEL);
        next_s.zero_hold = (next_s.state == motor_speed_pkg::ST_START_HOLD)
                        || (next_s.state == motor_speed_pkg::ST_STOP_HOLD);

        // pi update once per sample; acc holds ten times the torque reference
        if (s.tick) begin
            next_s.freq_target = 16'(32'(ramp_freq_in) - drop);
            next_s.torq_flt = s.torq_flt + (32'(load_torque_in) - s.torq_flt)
                              / wide(rt_safe);
            err = (s.zero_hold ? 32'sh00000000 : 32'(s.freq_target))
                  - 32'(actual_freq_in);
            delta = err - s.err_prev;
            if (closed_loop) begin
                acc_sum = s.acc + kp_eff * delta + (kp_eff * err) / wide(ti_safe);
            end else begin
                acc_sum = s.acc + wide(s.cfg[3]) * delta + wide(s.cfg[4]) * err;
            end
            if (!active) begin
                acc_sum = 32'sh00000000;
                err = 32'sh00000000;
            end
            if (acc_sum > `MSP_TORQ_LIM) begin
                acc_sum = `MSP_TORQ_LIM;
            end else if (acc_sum < -`MSP_TORQ_LIM) begin
                acc_sum = -`MSP_TORQ_LIM;
            end
            next_s.acc = acc_sum;
            next_s.err_prev = err;
            next_s.torque_ref = 16'(acc_sum / 32'sh0000000A);
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            s <= '0;
            s.cfg[5] <= `MSP_RST_CL_KP;
            s.cfg[6] <= `MSP_RST_CL_TI;
            s.cfg[11] <= `MSP_RST_PCT;
            s.cfg[12] <= `MSP_RST_PCT;
            s.cfg[14] <= `MSP_RST_FNOM;
            s.cfg[15] <= `MSP_RST_FNOM;
            s.state <= motor_speed_pkg::ST_IDLE;
        end else begin
            s <= next_s;
        end
    end

    assign rd_data_out      = s.rd_data;
    assign torque_ref_out   = s.torque_ref;
    assign freq_target_out  = s.freq_target;
    assign ramp_release_out = s.ramp_release;
    assign zero_hold_out    = s.zero_hold;

    sequence decel_at_zero_s;
        (s.state == motor_speed_pkg::ST_DECEL) && ramp_at_zero_in;
    endsequence
    sequence coast_stop_s;
        (s.state == motor_speed_pkg::ST_RUN) && stop_cmd_in && coast_stop;
    endsequence

    sample_period_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        s.tick |=> !s.tick [*8]) else $error("sample tick too frequent");
    coast_skip_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        coast_stop_s |=> (s.state == motor_speed_pkg::ST_IDLE) && !zero_hold_out)
        else $error("coast stop entered hold");
    stop_hold_entry_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        decel_at_zero_s |=> zero_hold_out && !ramp_release_out)
        else $error("stop hold did not start at ramp zero");
    ramp_release_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        $rose(ramp_release_out) |-> $past(s.state) == motor_speed_pkg::ST_START_HOLD)
        else $error("ramp released without start hold");
    stop_hold_time_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (s.state == motor_speed_pkg::ST_STOP_HOLD) && (s.hold_cnt <= s.cfg[8])
        |=> zero_hold_out) else $error("stop hold ended early");
    no_load_droop_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        s.tick && (load_torque_in == 16'sh0000) && (s.cfg[2] == 16'h0000)
        |=> freq_target_out == $past(ramp_freq_in)) else $error("droop without load");
    zero_speed_droop_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        s.tick && (droop_sel == 2'b10) && (spd == 16'h0000)
        |=> freq_target_out == $past(ramp_freq_in)) else $error("droop at zero speed");
    low_speed_gain_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (spd <= s.cfg[9]) && (spd < s.cfg[10]) && (spd < s.cfg[15])
        |-> gain_pct == wide(s.cfg[11])) else $error("low speed gain not applied");
    idle_torque_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (s.state == motor_speed_pkg::ST_IDLE) && s.tick ##1 (s.state == motor_speed_pkg::ST_IDLE)
        |-> torque_ref_out == 16'sh0000) else $error("torque in idle");

    sequence start_seen_s;
        (s.state == motor_speed_pkg::ST_IDLE) && start_cmd_in;
    endsequence
    sequence start_waiting_s;
        (s.state == motor_speed_pkg::ST_START_HOLD) && (s.hold_cnt <= s.cfg[7])
            && !stop_cmd_in;
    endsequence
    sequence start_expired_s;
        (s.state == motor_speed_pkg::ST_START_HOLD) && (s.hold_cnt > s.cfg[7])
            && !stop_cmd_in;
    endsequence
    sequence stop_expired_s;
        (s.state == motor_speed_pkg::ST_STOP_HOLD) && (s.hold_cnt > s.cfg[8]);
    endsequence
    sequence coast_in_hold_s;
        (s.state == motor_speed_pkg::ST_START_HOLD) && stop_cmd_in && coast_stop;
    endsequence
    start_entry_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        start_seen_s |=> zero_hold_out && !ramp_release_out)
        else $error("start did not enter hold");
    start_hold_min_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        start_waiting_s |=> zero_hold_out && !ramp_release_out)
        else $error("start hold ended early");
    start_release_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        start_expired_s |=> ramp_release_out && !zero_hold_out)
        else $error("ramp not released after start hold");
    decel_release_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (s.state == motor_speed_pkg::ST_DECEL) && !ramp_at_zero_in
        |=> ramp_release_out && !zero_hold_out)
        else $error("stop hold began before ramp zero");
    stop_hold_end_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        stop_expired_s |=> !zero_hold_out && !ramp_release_out)
        else $error("stop hold overran");
    hold_count_step_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (s.state == motor_speed_pkg::ST_STOP_HOLD) && (s.hold_cnt <= s.cfg[8]) && s.tick
        |=> s.hold_cnt == $past(s.hold_cnt) + 16'h0001) else $error("stop hold count lost");
    coast_from_hold_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        coast_in_hold_s |=> (s.state == motor_speed_pkg::ST_IDLE) && !zero_hold_out)
        else $error("coast stop from start hold kept holding");
    tick_counter_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        s.tick |-> s.div_cnt == 15'h0000) else $error("tick off the sample grid");
    torque_limit_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (torque_ref_out <= 16'sh0BB8) && (torque_ref_out >= -16'sh0BB8))
        else $error("torque reference beyond limit");
    outputs_steady_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        !s.tick |=> $stable(torque_ref_out) && $stable(freq_target_out))
        else $error("controller output moved between samples");
    idle_outputs_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        (s.state == motor_speed_pkg::ST_IDLE) |-> !zero_hold_out && !ramp_release_out)
        else $error("idle with hold or release");
    open_loop_gain_a : assert property (@(posedge ref_clk_in) disable iff (!rst_b_in)
        s.tick && !closed_loop && (s.state == motor_speed_pkg::ST_RUN)
        && (s.cfg[3] == 16'h0000) && (s.cfg[4] == 16'h0000)
        |=> s.acc == $past(s.acc)) else $error("open loop used closed loop gains");
endmodule : motor_speed_pi_droop_control

// ---- motor_load_model.sv ----
// far side model: shaft speed feedback and load torque source
`timescale 1ns/100ps
module motor_load_model (
    input  wire logic               ref_clk_in,
    input  wire logic               rst_b_in,
    input  wire logic signed [15:0] speed_set_in,
    input  wire logic signed [15:0] load_set_in,
    input  wire logic               slow_in,
    output logic signed [15:0]      actual_freq_out,
    output logic signed [15:0]      load_torque_out
);
    // slow mode slews one count a clock, like a shaft with inertia
    always_ff @(posedge ref_clk_in) begin
        if (!rst_b_in) begin
            actual_freq_out <= 16'sh0000;
            load_torque_out <= 16'sh0000;
        end else begin
            load_torque_out <= load_set_in;
            if (!slow_in || actual_freq_out == speed_set_in)
                actual_freq_out <= speed_set_in;
            else if (actual_freq_out < speed_set_in)
                actual_freq_out <= actual_freq_out + 16'sh0001;
            else
                actual_freq_out <= actual_freq_out - 16'sh0001;
        end
    end
endmodule : motor_load_model

// ---- test_motor_speed_pi_droop_control.sv ----
// self-checking bench of the speed control core
`timescale 1ns/100ps
`include "motor_speed_params.svh"
module test_motor_speed_pi_droop_control;
    localparam int SC = 20;
    logic               ref_clk_in, rst_b_in, wr_in, rd_in, slow;
    logic               start_cmd_in, stop_cmd_in, ramp_at_zero_in;
    logic               ramp_release_out, zero_hold_out;
    logic [7:0]         addr_in;
    logic [31:0]        wr_data_in, rd_data_out, d;
    logic signed [15:0] ramp_freq_in, actual_freq_in, load_torque_in, torque_ref_out;
    logic signed [15:0] freq_target_out, speed_set, load_set, t0;
    int                 fails, tests_run, n, ex;
    int                 tab [4][5] = '{'{1, 0, 0, 5000, 100}, '{1, 1000, 2000, 5000, 50},
                                       '{1, 0, 0, 50, 200}, '{0, 0, 0, 5000, 100}};

    motor_speed_pi_droop_control #(.SAMPLE_CYCLES(SC)) i_dut (.ref_clk_in(ref_clk_in),
        .rst_b_in(rst_b_in), .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
        .rd_in(rd_in), .rd_data_out(rd_data_out), .ramp_freq_in(ramp_freq_in),
        .actual_freq_in(actual_freq_in), .load_torque_in(load_torque_in),
        .start_cmd_in(start_cmd_in), .stop_cmd_in(stop_cmd_in),
        .ramp_at_zero_in(ramp_at_zero_in), .torque_ref_out(torque_ref_out),
        .freq_target_out(freq_target_out), .ramp_release_out(ramp_release_out),
        .zero_hold_out(zero_hold_out));
    motor_load_model i_load (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
        .speed_set_in(speed_set), .load_set_in(load_set), .slow_in(slow),
        .actual_freq_out(actual_freq_in), .load_torque_out(load_torque_in));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            fails++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wrap_up;
        if (fails == 0 && tests_run > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : wrap_up
    task automatic wr(input logic [7:0] a, input int v);
        @(posedge ref_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wr_data_in <= 32'(v);
        @(posedge ref_clk_in);
        wr_in <= 1'b0;
    endtask : wr
    // read data appear in the cycle after the strobe and hold until the next read
    task automatic rd(input logic [7:0] a);
        @(posedge ref_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge ref_clk_in);
        rd_in <= 1'b0;
        #1;
        d = rd_data_out;
    endtask : rd
    // k: 0 start, 1 stop, 2 ramp at zero
    task automatic pulse(input int k);
        @(posedge ref_clk_in);
        start_cmd_in <= (k == 0);
        stop_cmd_in <= (k == 1);
        ramp_at_zero_in <= (k == 2);
        @(posedge ref_clk_in);
        {start_cmd_in, stop_cmd_in, ramp_at_zero_in} <= 3'h0;
        #1;
    endtask : pulse
    task automatic count_until(input bit rel);
        n = 0;
        while ((rel ? ramp_release_out !== 1'b1 : zero_hold_out !== 1'b0) && n < 400) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
    endtask : count_until
    task automatic next_sample;
        logic signed [15:0] t;
        t = torque_ref_out;
        n = 0;
        while (torque_ref_out === t && n < 3 * SC) begin
            @(posedge ref_clk_in);
            #1;
            n++;
        end
    endtask : next_sample

    initial begin
        ref_clk_in = 1'b0;
        forever #25 ref_clk_in = ~ref_clk_in;
    end
    initial begin
        repeat (30000) @(posedge ref_clk_in);
        fails++;
        wrap_up();
    end
    initial begin
        {rst_b_in, wr_in, rd_in, slow, start_cmd_in, stop_cmd_in, ramp_at_zero_in} = 7'h00;
        addr_in = 8'h00;
        wr_data_in = 32'h0;
        {ramp_freq_in, speed_set, load_set} = 48'h0;
        void'($urandom(4757));
        repeat (5) @(posedge ref_clk_in);
        rst_b_in <= 1'b1;
        rd(`MSP_CL_KP);
        check(d, 32'h00000064);
        rd(`MSP_CL_TI);
        check(d, 32'h00000032);
        ex = $urandom_range(16'h7FFF, 1);
        wr(`MSP_CL_KP, ex);
        rd(`MSP_CL_KP);
        check(d, 32'(ex));
        rd(8'h4C);
        check(d, 32'h0);
        wr(`MSP_STATUS, 32'hFFFF);
        rd(`MSP_STATUS);
        check(d, 32'h0);
        wr(`MSP_START_HOLD, 3);
        wr(`MSP_STOP_HOLD, 2);
        wr(`MSP_CTRL, 1);
        slow <= 1'b1;
        pulse(0);
        check(zero_hold_out, 1'b1);
        count_until(1);
        check(32'(n >= 3 * SC - 1 && n <= 4 * SC + 2), 32'h1);
        pulse(1);
        check({ramp_release_out, zero_hold_out}, 2'b10);
        // actual speed is already zero, yet the hold must wait for the ramp
        repeat (10 * SC) @(posedge ref_clk_in);
        rd(`MSP_STATUS);
        check(d, 32'h0000000B);
        pulse(2);
        check({ramp_release_out, zero_hold_out}, 2'b01);
        count_until(0);
        check(32'(n >= 2 * SC - 1 && n <= 3 * SC + 2), 32'h1);
        wr(`MSP_CTRL, 3);
        pulse(0);
        count_until(1);
        pulse(1);
        check({ramp_release_out, zero_hold_out}, 2'b00);
        rd(`MSP_STATUS);
        check(d, 32'h0);
        // zero open loop gains keep the torque still while the run starts
        wr(`MSP_OL_P, 0);
        wr(`MSP_OL_I, 0);
        wr(`MSP_CTRL, 0);
        wr(`MSP_CL_TI, 10);
        wr(`MSP_CL_KP, 100);
        wr(`MSP_KP_F0, 50);
        wr(`MSP_KP_FW, 200);
        wr(`MSP_DROOP_PCT, 0);
        wr(`MSP_DROOP_TIME, 0);
        @(posedge ref_clk_in);
        speed_set <= 16'sh0064;
        ramp_freq_in <= 16'sh00C8;
        pulse(0);
        count_until(1);
        repeat (5 * SC) @(posedge ref_clk_in);
        for (int i = 0; i < 4; i++) begin
            wr(`MSP_CTRL, tab[i][0]);
            wr(`MSP_F0, tab[i][1]);
            wr(`MSP_F1, tab[i][2]);
            wr(`MSP_FW_POINT, tab[i][3]);
            wr(`MSP_OL_I, tab[i][0] ? 0 : 2);
            next_sample();
            t0 = torque_ref_out;
            next_sample();
            // error 1 Hz steady, so each sample adds only the integral share
            ex = tab[i][0] ? 100 * tab[i][4] / 100 * 100 / 10 / 10 : 2 * 100 / 10;
            check(32'(torque_ref_out - t0), 32'(ex));
        end
        wr(`MSP_DROOP_PCT, 100);
        wr(`MSP_ZERO_LIM, 10000);
        @(posedge ref_clk_in);
        speed_set <= 16'sh09C4;
        // speed must sit at its set point before the droop scaling is judged
        slow <= 1'b0;
        load_set <= 16'sh03E8;
        ramp_freq_in <= 16'(int'($urandom_range(9000, 1000)));
        for (int o = 0; o < 3; o++) begin
            wr(`MSP_CTRL, 1 | (o << 2));
            repeat (3 * SC) @(posedge ref_clk_in);
            #1;
            ex = 5000 * 100 * 1000 / 1000000;
            ex = (o == 0) ? ex : ex * 2500 / ((o == 1) ? 10000 : 5000);
            check(32'(freq_target_out), 32'(ramp_freq_in - ex));
        end
        // shaft at rest under option two: no droop is left at zero frequency
        @(posedge ref_clk_in);
        speed_set <= 16'sh0000;
        repeat (3 * SC) @(posedge ref_clk_in);
        #1;
        check(32'(freq_target_out), 32'(ramp_freq_in));
        // dynamic droop: the filtered torque catches up and the speed comes back
        wr(`MSP_CTRL, 1);
        wr(`MSP_DROOP_TIME, 1);
        repeat (3 * SC) @(posedge ref_clk_in);
        #1;
        check(32'(freq_target_out), 32'(ramp_freq_in));
        wrap_up();
    end
endmodule : test_motor_speed_pi_droop_control
